// ==== rtl/input_function_mapper_pkg.sv ====
// Constants, types and register map of the input function mapper.
package input_function_mapper_pkg;

	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int unsigned LINE_COUNT  = 4;
	localparam int unsigned FUNC_COUNT  = 11;
	localparam int unsigned DEB_WIDTH   = 16;
	localparam int unsigned TORQUE_W    = 16;

	// ************************************************************
	// Time base
	// ************************************************************
	localparam int unsigned CLK_HZ      = 100_000_000;
	localparam int unsigned MS_PER_TICK = 1;
	localparam int unsigned MS_CYCLES   = CLK_HZ / 1000 * MS_PER_TICK;

	// ************************************************************
	// Function indices
	// ************************************************************
	localparam int unsigned FN_TRAVEL_POS   = 0;
	localparam int unsigned FN_TRAVEL_NEG   = 1;
	localparam int unsigned FN_STOP         = 2;
	localparam int unsigned FN_VPRESET0     = 3;
	localparam int unsigned FN_VPRESET1     = 4;
	localparam int unsigned FN_TORQUE_LIMIT = 5;
	localparam int unsigned FN_TORQUE_MODE  = 6;
	localparam int unsigned FN_BRAKE_REL    = 7;
	localparam int unsigned FN_BRAKE_CTRL   = 8;
	localparam int unsigned FN_RESET        = 9;
	localparam int unsigned FN_VPRESET2     = 10;

	// ************************************************************
	// Register map (word aligned byte addresses)
	// ************************************************************
	localparam logic [7:0] ADDR_DEBOUNCE0 = 8'h00;
	localparam logic [7:0] ADDR_FUNC0     = 8'h10;
	localparam logic [7:0] ADDR_TLIMIT    = 8'h40;
	localparam logic [7:0] ADDR_LINES     = 8'h44;
	localparam logic [7:0] ADDR_FUNCS     = 8'h48;
	localparam logic [7:0] ADDR_PRESET    = 8'h4C;

	// Function config word fields.
	localparam int unsigned FCFG_SEL_LSB   = 0;
	localparam int unsigned FCFG_OFF_BIT   = 4;
	localparam int unsigned FCFG_ALWAYS_BIT = 5;

	localparam logic [2:0]          SEL_UNASSIGNED = 3'h0;
	localparam logic [DEB_WIDTH-1:0] DEB_RESET     = 16'h0000;
	localparam logic [TORQUE_W-1:0]  TLIMIT_RESET  = 16'h7FFF;

	// ************************************************************
	// Types
	// ************************************************************
	typedef struct packed {
		logic [2:0] sel;
		logic       active_off;
		logic       always_on;
	} func_cfg_t;

	typedef struct packed {
		logic       read;
		logic       write;
		logic [7:0] address;
		logic [31:0] writedata;
	} avmm_req_t;

endpackage : input_function_mapper_pkg

// ==== rtl/input_function_mapper.sv ====
// Input line debounce, function mapping, torque clamp and Avalon-MM slave.
`timescale 1ns/1ns
`default_nettype none
module input_function_mapper
	import input_function_mapper_pkg::*;
#(
	parameter int unsigned MS_TICK_CYCLES = MS_CYCLES
) (
	input  wire logic                          sys_clk,
	input  wire logic                          nrst,
	input  wire logic [LINE_COUNT-1:0]         line_in,
	input  wire logic signed [TORQUE_W-1:0]    torque_cmd_in,
	input  wire logic                          avs_read,
	input  wire logic                          avs_write,
	input  wire logic [7:0]                    avs_address,
	input  wire logic [31:0]                   avs_writedata,
	output var  logic [31:0]                   avs_readdata,
	output var  logic                          avs_waitrequest,
	output var  logic [FUNC_COUNT-1:0]         func_active,
	output var  logic [2:0]                    preset_sel,
	output var  logic signed [TORQUE_W-1:0]    torque_cmd_out
);

	// ************************************************************
	// Checks
	// ************************************************************
	// The status words pack four lines and sixteen-bit fields, so other
	// sizes are refused here instead of being silently truncated.
	if (MS_TICK_CYCLES < 1) begin : g_bad_tick
		$error("MS_TICK_CYCLES must be at least one");
	end
	if (LINE_COUNT != 4) begin : g_bad_lines
		$error("LINE_COUNT must be four for the line status word");
	end
	if (FUNC_COUNT > 21) begin : g_bad_funcs
		$error("FUNC_COUNT must fit the function status word");
	end
	if (DEB_WIDTH != 16 || TORQUE_W != 16) begin : g_bad_widths
		$error("Debounce and torque fields must be sixteen bits wide");
	end
	if (FN_VPRESET2 >= FUNC_COUNT || FN_TORQUE_LIMIT >= FUNC_COUNT) begin : g_bad_index
		$error("Preset and torque limit functions must exist");
	end

	// ************************************************************
	// Storage
	// ************************************************************
	avmm_req_t                  req;
	logic [LINE_COUNT-1:0]      sync_a;
	logic [LINE_COUNT-1:0]      sync_b;
	logic [LINE_COUNT-1:0]      line_valid;
	logic [DEB_WIDTH-1:0]       deb_time [LINE_COUNT];
	logic [DEB_WIDTH-1:0]       deb_cnt  [LINE_COUNT];
	func_cfg_t                  fcfg     [FUNC_COUNT];
	logic [TORQUE_W-1:0]        tlimit;
	logic [31:0]                tick_cnt;
	logic                       ms_tick;
	logic                       ack;
	logic [FUNC_COUNT-1:0]      next_func;

	// Bus answer sequence; one wait state per access.
	typedef enum logic [0:0] {
		BUS_IDLE   = 1'b0,
		BUS_ANSWER = 1'b1
	} bus_state_t;
	bus_state_t                 bus_state;
	bus_state_t                 next_bus_state;
	logic signed [TORQUE_W-1:0] next_torque;
	logic [31:0]                next_readdata;
	logic                       wr_take;
	logic                       rd_start;

	assign req = '{read: avs_read, write: avs_write, address: avs_address,
		writedata: avs_writedata};

	// Resolve one function from its configuration and the debounced lines.
	function automatic logic resolve(input func_cfg_t c, input logic [LINE_COUNT-1:0] lv);
		logic lvl;
		logic assigned;
		lvl      = 1'b0;
		assigned = (c.sel != SEL_UNASSIGNED) && (c.sel <= 3'(LINE_COUNT));
		if (assigned)
			lvl = lv[2'(c.sel - 3'h1)];
		return c.always_on | (assigned & (lvl ^ c.active_off));
	endfunction : resolve

	// ************************************************************
	// Line synchroniser
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= line_in;
			sync_b <= sync_a;
		end
	end

	// ************************************************************
	// Millisecond time base
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			tick_cnt <= '0;
			ms_tick  <= 1'b0;
		end else if (tick_cnt >= MS_TICK_CYCLES - 1) begin
			tick_cnt <= '0;
			ms_tick  <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
			ms_tick  <= 1'b0;
		end
	end

	// ************************************************************
	// Debounce per line
	// ************************************************************
	// Whole milliseconds are counted on the shared tick, so the first
	// millisecond may be up to one tick short; one extra tick is counted
	// to keep the figure a least time.
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < LINE_COUNT; i++) begin
			if (!nrst) begin
				deb_cnt[i]    <= '0;
				line_valid[i] <= 1'b0;
			end else if (!sync_b[i]) begin
				deb_cnt[i]    <= '0;
				line_valid[i] <= 1'b0;
			end else if (deb_time[i] == DEB_RESET) begin
				line_valid[i] <= 1'b1;
			end else if (deb_cnt[i] > deb_time[i]) begin
				line_valid[i] <= 1'b1;
			end else if (ms_tick) begin
				deb_cnt[i] <= deb_cnt[i] + 16'h0001;
			end
		end
	end

	// ************************************************************
	// Function resolution
	// ************************************************************
	always_comb begin
		for (int f = 0; f < FUNC_COUNT; f++)
			next_func[f] = resolve(fcfg[f], line_valid);
	end

	// Both outputs come from the same resolution, so the preset code never
	// disagrees with the preset flags on func_active.
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			func_active <= '0;
		end else begin
			func_active <= next_func;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			preset_sel <= 3'h0;
		end else begin
			preset_sel <= {next_func[FN_VPRESET2], next_func[FN_VPRESET1],
				next_func[FN_VPRESET0]};
		end
	end

	// ************************************************************
	// Torque clamp
	// ************************************************************
	// Limit the magnitude of a command. The limit register keeps its top bit
	// clear, so the negated limit is always representable.
	function automatic logic signed [TORQUE_W-1:0] clamp_torque(
		input logic signed [TORQUE_W-1:0] cmd,
		input logic        [TORQUE_W-1:0] lim
	);
		logic signed [TORQUE_W-1:0] pos;
		logic signed [TORQUE_W-1:0] neg;
		pos = $signed(lim);
		neg = -$signed(lim);
		if (cmd > pos)
			return pos;
		if (cmd < neg)
			return neg;
		return cmd;
	endfunction : clamp_torque

	// The clamp uses this cycle's resolution, so the clamped value and the
	// torque limit flag on func_active change on the same edge.
	always_comb begin
		if (next_func[FN_TORQUE_LIMIT]) begin
			next_torque = clamp_torque(torque_cmd_in, tlimit);
		end else begin
			next_torque = torque_cmd_in;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			torque_cmd_out <= '0;
		end else begin
			torque_cmd_out <= next_torque;
		end
	end

	// ************************************************************
	// Register decode
	// ************************************************************
	function automatic logic is_deb_addr(input logic [7:0] a, input int unsigned i);
		return a == ADDR_DEBOUNCE0 + 8'(4 * i);
	endfunction : is_deb_addr

	function automatic logic is_func_addr(input logic [7:0] a, input int unsigned f);
		return a == ADDR_FUNC0 + 8'(4 * f);
	endfunction : is_func_addr

	// ************************************************************
	// Avalon-MM slave
	// ************************************************************
	// Every access is answered one cycle after it is raised, so
	// waitrequest drops in the second cycle of each request.
	always_comb begin
		next_bus_state = BUS_IDLE;
		unique case (bus_state)
			BUS_IDLE: begin
				if (req.read || req.write) begin
					next_bus_state = BUS_ANSWER;
				end
			end
			BUS_ANSWER: begin
				next_bus_state = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			bus_state <= BUS_IDLE;
		end else begin
			bus_state <= next_bus_state;
		end
	end

	// Writes land at the edge that ends the answer cycle; read data is
	// loaded one edge earlier so that it stands during that cycle.
	assign ack      = (bus_state == BUS_ANSWER);
	assign wr_take  = req.write && ack;
	assign rd_start = req.read && !ack;

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= (next_bus_state != BUS_ANSWER);
		end
	end

	// ************************************************************
	// Register bank
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < LINE_COUNT; i++) begin
			if (!nrst) begin
				deb_time[i] <= DEB_RESET;
			end else if (wr_take && is_deb_addr(req.address, i)) begin
				deb_time[i] <= req.writedata[DEB_WIDTH-1:0];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		for (int f = 0; f < FUNC_COUNT; f++) begin
			if (!nrst) begin
				fcfg[f] <= '{sel: SEL_UNASSIGNED, active_off: 1'b0, always_on: 1'b0};
			end else if (wr_take && is_func_addr(req.address, f)) begin
				fcfg[f] <= '{sel: req.writedata[FCFG_SEL_LSB +: 3],
					active_off: req.writedata[FCFG_OFF_BIT],
					always_on: req.writedata[FCFG_ALWAYS_BIT]};
			end
		end
	end

	// Bit 15 is forced clear so the limit is always a magnitude.
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			tlimit <= TLIMIT_RESET;
		end else if (wr_take && req.address == ADDR_TLIMIT) begin
			tlimit <= {1'b0, req.writedata[TORQUE_W-2:0]};
		end
	end

	// ************************************************************
	// Readback
	// ************************************************************
	// Unmapped addresses read as zero, and read data is zero outside
	// the answer cycle.
	always_comb begin
		next_readdata = 32'h0000_0000;
		if (rd_start) begin
			for (int i = 0; i < LINE_COUNT; i++) begin
				if (is_deb_addr(req.address, i)) begin
					next_readdata = {16'h0000, deb_time[i]};
				end
			end
			for (int f = 0; f < FUNC_COUNT; f++) begin
				if (is_func_addr(req.address, f)) begin
					next_readdata = {26'h000_0000, fcfg[f].always_on,
						fcfg[f].active_off, 1'b0, fcfg[f].sel};
				end
			end
			case (req.address)
				ADDR_TLIMIT: begin
					next_readdata = {16'h0000, tlimit};
				end
				ADDR_LINES: begin
					next_readdata = {24'h00_0000, sync_b, line_valid};
				end
				ADDR_FUNCS: begin
					next_readdata = {21'h00_0000, func_active};
				end
				ADDR_PRESET: begin
					next_readdata = {29'h0000_0000, preset_sel};
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			avs_readdata <= '0;
		end else begin
			avs_readdata <= next_readdata;
		end
	end

endmodule : input_function_mapper
`default_nettype wire

// ==== verification/ifm_checker_assertions.sv ====
// Port assertions for the input function mapper.
`timescale 1ns/1ns
`default_nettype none
module ifm_checker import input_function_mapper_pkg::*; #(
	parameter int unsigned MS_TICK_CYCLES = MS_CYCLES
) (
	input wire logic                       sys_clk,
	input wire logic                       nrst,
	input wire logic                       avs_read,
	input wire logic                       avs_write,
	input wire logic [31:0]                avs_readdata,
	input wire logic                       avs_waitrequest,
	input wire logic [FUNC_COUNT-1:0]      func_active,
	input wire logic [2:0]                 preset_sel,
	input wire logic signed [TORQUE_W-1:0] torque_cmd_in,
	input wire logic signed [TORQUE_W-1:0] torque_cmd_out
);
	// ************************************************************
	// Properties
	// ************************************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	property p_wait_rise; $rose(avs_read) || $rose(avs_write) |=> !avs_waitrequest; endproperty
	a_wait_rise: assert property (p_wait_rise) else $error("no answer to request");
	property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait low too long");
	property p_idle; !avs_read && !avs_write |=> avs_waitrequest; endproperty
	a_idle: assert property (p_idle) else $error("answer without request");
	property p_rd_zero; avs_waitrequest |-> avs_readdata == 32'h0000_0000; endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("read data outside answer");
	property p_rst; $past(!nrst) |-> func_active == '0 && torque_cmd_out == '0; endproperty
	a_rst: assert property (p_rst) else $error("outputs not clear after reset");
	property p_pass;
		$past(nrst) && !func_active[FN_TORQUE_LIMIT] |-> torque_cmd_out == $past(torque_cmd_in);
	endproperty
	a_pass: assert property (p_pass) else $error("torque altered while unclamped");
	property p_pos;
		$past(nrst) && $past(torque_cmd_in) >= 0 |->
			torque_cmd_out >= 0 && torque_cmd_out <= $past(torque_cmd_in);
	endproperty
	a_pos: assert property (p_pos) else $error("positive torque grew");
	property p_neg;
		$past(nrst) && $past(torque_cmd_in) < 0 |->
			torque_cmd_out <= 0 && torque_cmd_out >= $past(torque_cmd_in);
	endproperty
	a_neg: assert property (p_neg) else $error("negative torque grew");
	property p_preset; preset_sel == {func_active[10], func_active[4], func_active[3]}; endproperty
	a_preset: assert property (p_preset) else $error("preset code mismatch");
	c_write: cover property (avs_write && !avs_waitrequest);
	c_clamp: cover property (func_active[FN_TORQUE_LIMIT] && torque_cmd_out != $past(torque_cmd_in));
	c_preset: cover property (preset_sel == 3'h7);
endmodule : ifm_checker
bind input_function_mapper ifm_checker #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) chk_u (
	.sys_clk(sys_clk), .nrst(nrst), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.func_active(func_active), .preset_sel(preset_sel),
	.torque_cmd_in(torque_cmd_in), .torque_cmd_out(torque_cmd_out)
);
`default_nettype wire

// ==== verification/switch_bank.sv ====
// Switch bank model that drives the raw input lines.
`timescale 1ns/1ns
`default_nettype none
module switch_bank (
	input  wire logic       sys_clk,
	input  wire logic [3:0] want,
	output logic      [3:0] line_in
);
	// Contacts move just after an edge, so the sampler never sees a change on it.
	initial line_in = 4'h0;
	always @(posedge sys_clk) line_in <= want;
endmodule : switch_bank
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the input function mapper.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import input_function_mapper_pkg::*;
	logic               sys_clk, nrst, avs_read, avs_write, avs_waitrequest;
	logic [7:0]         avs_address;
	logic [31:0]        avs_writedata, avs_readdata, q;
	logic [3:0]         want, line_in;
	logic signed [15:0] tin, tout;
	logic [10:0]        fa;
	logic [2:0]         ps;
	int                 err_count, num_checks, cyc;
	input_function_mapper #(.MS_TICK_CYCLES(10)) dut_u (
		.sys_clk(sys_clk), .nrst(nrst), .line_in(line_in), .torque_cmd_in(tin),
		.avs_read(avs_read), .avs_write(avs_write), .avs_address(avs_address),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .func_active(fa), .preset_sel(ps),
		.torque_cmd_out(tout)
	);
	switch_bank sw_u (.sys_clk(sys_clk), .want(want), .line_in(line_in));
	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	// Reads and writes alike; the slave's own wait state decides the length.
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic fcfg(input int f, input logic [2:0] s, input logic off, input logic alw);
		bus(1'b1, 8'h10 + 8'(4 * f), {10'h000, alw, off, 1'b0, s});
	endtask : fcfg
	task automatic at(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : at
	task automatic t_regs;
		bus(1'b0, ADDR_DEBOUNCE0, 16'h0000);
		chk(q[15:0], DEB_RESET);
		bus(1'b0, ADDR_FUNC0, 16'h0000);
		chk(q[15:0], 16'h0000);
		bus(1'b0, ADDR_TLIMIT, 16'h0000);
		chk(q[15:0], TLIMIT_RESET);
		bus(1'b0, 8'h80, 16'h0000);
		chk(q[15:0], 16'h0000);
		chk(fa, 16'h0000);
		$display("registers done");
	endtask : t_regs
	task automatic t_map;
		fcfg(FN_STOP, 3'h2, 1'b0, 1'b0);
		fcfg(FN_TRAVEL_NEG, 3'h2, 1'b1, 1'b0);
		want <= 4'b0010;
		at(8);
		chk(fa[FN_STOP], 1'b1);
		chk(fa[FN_TRAVEL_NEG], 1'b0);
		chk(fa[FN_TRAVEL_POS], 1'b0);
		@(posedge sys_clk);
		want <= 4'b0000;
		at(8);
		chk(fa[FN_STOP], 1'b0);
		chk(fa[FN_TRAVEL_NEG], 1'b1);
		$display("mapping done");
	endtask : t_map
	task automatic t_always;
		fcfg(FN_RESET, 3'h0, 1'b0, 1'b1);
		fcfg(FN_BRAKE_REL, 3'h1, 1'b1, 1'b1);
		want <= 4'b0001;
		at(8);
		chk(fa[FN_RESET], 1'b1);
		chk(fa[FN_BRAKE_REL], 1'b1);
		fcfg(FN_BRAKE_REL, 3'h1, 1'b1, 1'b0);
		at(5);
		chk(fa[FN_BRAKE_REL], 1'b0);
		$display("always active done");
	endtask : t_always
	task automatic t_deb;
		int n;
		bus(1'b1, ADDR_DEBOUNCE0 + 8'h08, 16'h0002);
		fcfg(FN_TORQUE_MODE, 3'h3, 1'b0, 1'b0);
		fcfg(FN_BRAKE_CTRL, 3'h4, 1'b0, 1'b0);
		want <= 4'b1101;
		at(6);
		chk(fa[FN_BRAKE_CTRL], 1'b1);
		chk(fa[FN_TORQUE_MODE], 1'b0);
		at(10);
		@(posedge sys_clk);
		want[2] <= 1'b0;
		@(posedge sys_clk);
		want[2] <= 1'b1;
		at(19);
		chk(fa[FN_TORQUE_MODE], 1'b0);
		n = 0;
		while (fa[FN_TORQUE_MODE] !== 1'b1 && n < 40) begin
			at(1);
			n++;
		end
		chk(fa[FN_TORQUE_MODE], 1'b1);
		$display("debounce done");
	endtask : t_deb
	task automatic t_torque;
		bus(1'b1, ADDR_TLIMIT, 16'h0064);
		fcfg(FN_TORQUE_LIMIT, 3'h0, 1'b0, 1'b1);
		tin <= 16'h01F4;
		at(5);
		chk(tout, 16'h0064);
		@(posedge sys_clk);
		tin <= 16'hFE0C;
		at(2);
		chk(tout, 16'hFF9C);
		fcfg(FN_TORQUE_LIMIT, 3'h0, 1'b0, 1'b0);
		at(5);
		chk(tout, 16'hFE0C);
		$display("torque done");
	endtask : t_torque
	task automatic t_preset;
		for (int c = 0; c < 8; c++) begin
			fcfg(FN_VPRESET0, 3'h0, 1'b0, c[0]);
			fcfg(FN_VPRESET1, 3'h0, 1'b0, c[1]);
			fcfg(FN_VPRESET2, 3'h0, 1'b0, c[2]);
			at(5);
			chk(ps, 16'(c));
		end
		$display("presets done");
	endtask : t_preset
	// ************************************************************
	// Sequence
	// ************************************************************
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count++;
			results();
		end
	end
	initial begin
		{nrst, avs_read, avs_write, avs_address, avs_writedata} = '0;
		{want, tin, err_count, num_checks} = '0;
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		t_regs();
		t_map();
		t_always();
		t_deb();
		t_torque();
		t_preset();
		results();
	end
endmodule : tb_top
`default_nettype wire
